// *** clkgen_defines.svh ***
// Bit positions, widths and reset values of the clock generator configuration space
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// ****************************************
// Configuration space
// ****************************************
`define CFG_BYTES 16
`define CFG_BITS 128
`define CFG_RESET 8'h00

// ****************************************
// PLL fields
// ****************************************
`define REF_A_LSB 0
`define REF_B_LSB 24
`define REF_C0_LSB 48
`define REF_C1_LSB 72
`define LOOP_A_LSB 8
`define LOOP_B_LSB 32
`define LOOP_C0_LSB 56
`define LOOP_C1_LSB 80
`define PUMP_A_BIT 19
`define PUMP_B_BIT 43
`define PUMP_C0_BIT 67
`define PUMP_C1_BIT 91
`define FILT_A_BIT 20
`define FILT_B_BIT 44
`define FILT_C0_BIT 68
`define FILT_C1_BIT 92
`define LOOP_OFF_A_BIT 21
`define LOOP_OFF_B_BIT 45
`define LOOP_OFF_C_BIT 69

// ****************************************
// Output path fields
// ****************************************
`define SRC_A_LSB 22
`define SRC_B_LSB 46
`define SRC_C0_LSB 70
`define SRC_C1_LSB 124
`define SRC_D0_LSB 94
`define SRC_D1_LSB 126
`define DIV_A_LSB 96
`define DIV_B_LSB 100
`define DIV_C0_LSB 104
`define DIV_D0_LSB 108
`define DIV_C1_LSB 112
`define DIV_D1_LSB 116
`define OUT_OFF_LSB 120

`endif

// *** clkgen_pkg.sv ***
// Types shared by the clock generator configuration decoder
package clkgen_pkg;
  typedef logic [7:0] ref_div_t;
  typedef logic [10:0] loop_div_t;
  typedef logic [3:0] div_code_t;
  typedef logic [5:0] modulus_t;
  typedef enum logic [1:0] {
    SRC_REF = 2'b00,
    SRC_PLL_A = 2'b01,
    SRC_PLL_B = 2'b10,
    SRC_PLL_C = 2'b11
  } source_t;
endpackage : clkgen_pkg

// *** config_store.sv ***
// Sixteen byte configuration store with registered read data
`timescale 1ns/1ps
`include "clkgen_defines.svh"
module config_store (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Byte access
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Whole space
  output logic [127:0] bits
);
  logic [7:0] mem_ff [`CFG_BYTES];
  logic [7:0] rdata_ff;

  genvar i;
  generate
    for (i = 0; i < `CFG_BYTES; i++) begin : g_byte
      // All bits clear at reset
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) mem_ff[i] <= `CFG_RESET;
        else if (wr && addr == 4'(i)) mem_ff[i] <= wdata;
      end
      assign bits[8*i +: 8] = mem_ff[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rdata_ff <= `CFG_RESET;
    else rdata_ff <= mem_ff[addr];
  end

  assign rdata = rdata_ff;
endmodule : config_store

// *** out_divider.sv ***
// Output post divider counting rising edges of the selected source
`timescale 1ns/1ps
module out_divider
  import clkgen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic src_level,
  input wire div_code_t code,
  input wire logic off,
  // Divided clock
  output logic div_clk
);
  // Modulus table, code bit 3 most significant
  function automatic modulus_t modulus(input div_code_t c);
    unique case (c)
      4'h0: modulus = 6'd1;
      4'h1: modulus = 6'd2;
      4'h2: modulus = 6'd3;
      4'h3: modulus = 6'd4;
      4'h4: modulus = 6'd5;
      4'h5: modulus = 6'd6;
      4'h6: modulus = 6'd8;
      4'h7: modulus = 6'd9;
      4'h8: modulus = 6'd10;
      4'h9: modulus = 6'd12;
      4'ha: modulus = 6'd15;
      4'hb: modulus = 6'd16;
      4'hc: modulus = 6'd18;
      4'hd: modulus = 6'd20;
      4'he: modulus = 6'd25;
      4'hf: modulus = 6'd50;
    endcase
  endfunction : modulus

  div_code_t code_ff;
  logic [5:0] cnt_ff;
  logic src_ff;
  logic out_ff;
  modulus_t mod;
  logic [5:0] half;
  logic rise;
  logic code_change;
  logic [5:0] nxt_cnt;
  logic nxt_out;

  assign mod = modulus(code_ff);
  assign half = 6'((mod + 6'd1) >> 1);
  assign rise = src_level && !src_ff;
  assign code_change = code != code_ff;
  assign nxt_cnt = code_change ? 6'd0 :
                   !rise ? cnt_ff :
                   (cnt_ff == mod - 6'd1) ? 6'd0 : 6'(cnt_ff + 6'd1);
  assign nxt_out = off ? 1'b0 :
                   (mod == 6'd1) ? src_level : (nxt_cnt < half);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_ff <= 4'h0;
      cnt_ff <= 6'd0;
      src_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      code_ff <= code;
      cnt_ff <= off ? 6'd0 : nxt_cnt;
      src_ff <= src_level;
      out_ff <= nxt_out;
    end
  end

  assign div_clk = out_ff;
endmodule : out_divider

// *** clkgen_config.sv ***
// Configuration decoder of a three-loop clock generator with four output paths
`timescale 1ns/1ps
`include "clkgen_defines.svh"
module clkgen_config
  import clkgen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration byte port from the serial interface
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Pins
  input wire logic set_select_pin,
  input wire logic shutdown_input_pin,
  // Source clock levels: reference, loop A, loop B, loop C
  input wire logic [3:0] src_level,
  // Loop A settings
  output ref_div_t ref_divide_a,
  output logic [2:0] a_count_a,
  output logic [7:0] m_count_a,
  output logic filter_long_a,
  output logic pump_high_a,
  output logic loop_a_off,
  // Loop B settings
  output ref_div_t ref_divide_b,
  output logic [2:0] a_count_b,
  output logic [7:0] m_count_b,
  output logic filter_long_b,
  output logic pump_high_b,
  output logic loop_b_off,
  // Loop C settings, all but loop_c_off chosen by the select pin
  output ref_div_t ref_divide_c,
  output logic [2:0] a_count_c,
  output logic [7:0] m_count_c,
  output logic filter_long_c,
  output logic pump_high_c,
  output logic loop_c_off,
  // Output paths A to D
  output logic [1:0] path_a_source,
  output logic [1:0] path_b_source,
  output logic [1:0] path_c_source,
  output logic [1:0] path_d_source,
  output logic [3:0] out_off,
  output logic [3:0] out_clk
);

  // ****************************************
  // Configuration space
  // ****************************************
  logic [127:0] cfg;

  config_store u_store (
    .clk(clk),
    .resetn(resetn),
    .wr(cfg_wr),
    .addr(cfg_addr),
    .wdata(cfg_wdata),
    .rdata(cfg_rdata),
    .bits(cfg)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] pin_ff;
  logic [1:0] pin_raw;
  logic [1:0] pin_agree;
  logic [1:0] nxt_pin;

  assign pin_raw = {shutdown_input_pin, set_select_pin};
  assign pin_agree = ~(s2_ff ^ s3_ff);
  assign nxt_pin = (pin_agree & s3_ff) | (~pin_agree & pin_ff);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= 2'b00;
      s2_ff <= 2'b00;
      s3_ff <= 2'b00;
      pin_ff <= 2'b00;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= nxt_pin;
    end
  end

  logic set_sel;
  logic shutdown;

  assign set_sel = pin_ff[0];
  assign shutdown = pin_ff[1];

  // ****************************************
  // Stored fields
  // ****************************************
  ref_div_t ref_divide_c_set0;
  ref_div_t ref_divide_c_set1;
  loop_div_t loop_divide_a;
  loop_div_t loop_divide_b;
  loop_div_t loop_divide_c_set0;
  loop_div_t loop_divide_c_set1;
  div_code_t out_divide_a;
  div_code_t out_divide_b;
  div_code_t out_divide_c_set0;
  div_code_t out_divide_c_set1;
  div_code_t out_divide_d_set0;
  div_code_t out_divide_d_set1;
  logic [1:0] path_c_source_set0;
  logic [1:0] path_c_source_set1;
  logic [1:0] path_d_source_set0;
  logic [1:0] path_d_source_set1;
  logic loop_a_shutdown_enable;
  logic loop_b_shutdown_enable;
  logic loop_c_shutdown_enable;
  logic [3:0] out_divider_shutdown_enable;
  logic filter_time_a;
  logic filter_time_b;
  logic filter_time_c_set0;
  logic filter_time_c_set1;
  logic pump_current_a;
  logic pump_current_b;
  logic pump_current_c_set0;
  logic pump_current_c_set1;
  logic [1:0] path_a_field;
  logic [1:0] path_b_field;

  assign ref_divide_c_set0 = cfg[`REF_C0_LSB +: 8];
  assign ref_divide_c_set1 = cfg[`REF_C1_LSB +: 8];
  assign loop_divide_a = cfg[`LOOP_A_LSB +: 11];
  assign loop_divide_b = cfg[`LOOP_B_LSB +: 11];
  assign loop_divide_c_set0 = cfg[`LOOP_C0_LSB +: 11];
  assign loop_divide_c_set1 = cfg[`LOOP_C1_LSB +: 11];
  assign out_divide_a = cfg[`DIV_A_LSB +: 4];
  assign out_divide_b = cfg[`DIV_B_LSB +: 4];
  assign out_divide_c_set0 = cfg[`DIV_C0_LSB +: 4];
  assign out_divide_d_set0 = cfg[`DIV_D0_LSB +: 4];
  assign out_divide_c_set1 = cfg[`DIV_C1_LSB +: 4];
  assign out_divide_d_set1 = cfg[`DIV_D1_LSB +: 4];
  assign path_c_source_set0 = cfg[`SRC_C0_LSB +: 2];
  assign path_c_source_set1 = cfg[`SRC_C1_LSB +: 2];
  assign path_d_source_set0 = cfg[`SRC_D0_LSB +: 2];
  assign path_d_source_set1 = cfg[`SRC_D1_LSB +: 2];
  assign loop_a_shutdown_enable = cfg[`LOOP_OFF_A_BIT];
  assign loop_b_shutdown_enable = cfg[`LOOP_OFF_B_BIT];
  assign loop_c_shutdown_enable = cfg[`LOOP_OFF_C_BIT];
  assign out_divider_shutdown_enable = cfg[`OUT_OFF_LSB +: 4];
  assign filter_time_a = cfg[`FILT_A_BIT];
  assign filter_time_b = cfg[`FILT_B_BIT];
  assign filter_time_c_set0 = cfg[`FILT_C0_BIT];
  assign filter_time_c_set1 = cfg[`FILT_C1_BIT];
  assign pump_current_a = cfg[`PUMP_A_BIT];
  assign pump_current_b = cfg[`PUMP_B_BIT];
  assign pump_current_c_set0 = cfg[`PUMP_C0_BIT];
  assign pump_current_c_set1 = cfg[`PUMP_C1_BIT];
  assign path_a_field = cfg[`SRC_A_LSB +: 2];
  assign path_b_field = cfg[`SRC_B_LSB +: 2];

  // ****************************************
  // Set selection for loop C and paths C, D
  // ****************************************
  ref_div_t sel_ref_c;
  loop_div_t sel_loop_c;
  logic sel_filt_c;
  logic sel_pump_c;
  div_code_t sel_div_c;
  div_code_t sel_div_d;
  logic [1:0] sel_src_c;
  logic [1:0] sel_src_d;

  assign sel_ref_c = set_sel ? ref_divide_c_set1 : ref_divide_c_set0;
  assign sel_loop_c = set_sel ? loop_divide_c_set1 : loop_divide_c_set0;
  assign sel_filt_c = set_sel ? filter_time_c_set1 : filter_time_c_set0;
  assign sel_pump_c = set_sel ? pump_current_c_set1 : pump_current_c_set0;
  assign sel_div_c = set_sel ? out_divide_c_set1 : out_divide_c_set0;
  assign sel_div_d = set_sel ? out_divide_d_set1 : out_divide_d_set0;
  assign sel_src_c = set_sel ? path_c_source_set1 : path_c_source_set0;
  assign sel_src_d = set_sel ? path_d_source_set1 : path_d_source_set0;

  // ****************************************
  // Shutdown gating
  // ****************************************
  logic [2:0] nxt_loop_off;
  logic [3:0] nxt_out_off;

  assign nxt_loop_off = {3{shutdown}} & {loop_c_shutdown_enable,
                                         loop_b_shutdown_enable,
                                         loop_a_shutdown_enable};
  assign nxt_out_off = {4{shutdown}} & out_divider_shutdown_enable;

  // ****************************************
  // Registered loop settings
  // ****************************************
  // Loop fields pass straight through; the analog loop slews to the new value
  ref_div_t ref_a_ff;
  ref_div_t ref_b_ff;
  ref_div_t ref_c_ff;
  loop_div_t loop_a_ff;
  loop_div_t loop_b_ff;
  loop_div_t loop_c_ff;
  logic [2:0] filt_ff;
  logic [2:0] pump_ff;
  logic [2:0] loop_off_ff;
  logic [2:0] nxt_filt;
  logic [2:0] nxt_pump;

  assign nxt_filt = {sel_filt_c, filter_time_b, filter_time_a};
  assign nxt_pump = {sel_pump_c, pump_current_b, pump_current_a};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_a_ff <= 8'h00;
      loop_a_ff <= 11'h000;
    end else begin
      ref_a_ff <= cfg[`REF_A_LSB +: 8];
      loop_a_ff <= loop_divide_a;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_b_ff <= 8'h00;
      loop_b_ff <= 11'h000;
    end else begin
      ref_b_ff <= cfg[`REF_B_LSB +: 8];
      loop_b_ff <= loop_divide_b;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_c_ff <= 8'h00;
      loop_c_ff <= 11'h000;
    end else begin
      ref_c_ff <= sel_ref_c;
      loop_c_ff <= sel_loop_c;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filt_ff <= 3'h0;
      pump_ff <= 3'h0;
      loop_off_ff <= 3'h0;
    end else begin
      filt_ff <= nxt_filt;
      pump_ff <= nxt_pump;
      loop_off_ff <= nxt_loop_off;
    end
  end

  assign ref_divide_a = ref_a_ff;
  assign ref_divide_b = ref_b_ff;
  assign ref_divide_c = ref_c_ff;
  assign a_count_a = loop_a_ff[2:0];
  assign m_count_a = loop_a_ff[10:3];
  assign a_count_b = loop_b_ff[2:0];
  assign m_count_b = loop_b_ff[10:3];
  assign a_count_c = loop_c_ff[2:0];
  assign m_count_c = loop_c_ff[10:3];
  assign filter_long_a = filt_ff[0];
  assign filter_long_b = filt_ff[1];
  assign filter_long_c = filt_ff[2];
  assign pump_high_a = pump_ff[0];
  assign pump_high_b = pump_ff[1];
  assign pump_high_c = pump_ff[2];
  assign loop_a_off = loop_off_ff[0];
  assign loop_b_off = loop_off_ff[1];
  assign loop_c_off = loop_off_ff[2];

  // ****************************************
  // Output paths
  // ****************************************
  logic [1:0] path_src [4];
  div_code_t path_code [4];
  logic [7:0] src_ff;
  logic [3:0] out_off_ff;

  assign path_src[0] = path_a_field;
  assign path_src[1] = path_b_field;
  assign path_src[2] = sel_src_c;
  assign path_src[3] = sel_src_d;
  assign path_code[0] = out_divide_a;
  assign path_code[1] = out_divide_b;
  assign path_code[2] = sel_div_c;
  assign path_code[3] = sel_div_d;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_ff <= 8'h00;
      out_off_ff <= 4'h0;
    end else begin
      src_ff <= {path_src[3], path_src[2], path_src[1], path_src[0]};
      out_off_ff <= nxt_out_off;
    end
  end

  assign path_a_source = src_ff[1:0];
  assign path_b_source = src_ff[3:2];
  assign path_c_source = src_ff[5:4];
  assign path_d_source = src_ff[7:6];
  assign out_off = out_off_ff;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_path
      logic chosen;

      // Source switch is immediate and may glitch the output
      assign chosen = src_level[path_src[p]];

      out_divider u_div (
        .clk(clk),
        .resetn(resetn),
        .src_level(chosen),
        .code(path_code[p]),
        .off(nxt_out_off[p]),
        .div_clk(out_clk[p])
      );
    end
  endgenerate

endmodule : clkgen_config

// *** cfg_checker_assertions.sv ***
// Assertions on the ports of the configuration decoder
`timescale 1ns/1ps
module cfg_checker
  import clkgen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Config port and pins
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic set_select_pin,
  input wire logic shutdown_input_pin,
  // Decoded outputs
  input wire ref_div_t ref_divide_a,
  input wire ref_div_t ref_divide_b,
  input wire logic [2:0] a_count_a,
  input wire logic [7:0] m_count_a,
  input wire logic filter_long_a,
  input wire logic pump_high_a,
  input wire logic filter_long_c,
  input wire logic pump_high_c,
  input wire logic loop_a_off,
  input wire logic [1:0] path_a_source,
  input wire logic [3:0] out_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****
  // Byte write hits
  // ****
  wire [15:0] hit = cfg_wr ? 16'h0001 << cfg_addr : 16'h0000;
  a_ref_a: assert property (hit[0] ##1 !hit[0] |-> ##1
    ref_divide_a == $past(cfg_wdata, 2)) else $error("ref divider A wrong");
  a_ref_b: assert property (hit[3] ##1 !hit[3] |-> ##1
    ref_divide_b == $past(cfg_wdata, 2)) else $error("ref divider B wrong");
  a_loop_split_a: assert property (hit[1] ##1 !hit[1] |-> ##1
    a_count_a == $past(cfg_wdata[2:0], 2) && m_count_a[4:0] == $past(cfg_wdata[7:3], 2))
    else $error("loop divider A split wrong");
  a_tune_a: assert property (hit[2] ##1 !hit[2] |-> ##1
    m_count_a[7:5] == $past(cfg_wdata[2:0], 2) && pump_high_a == $past(cfg_wdata[3], 2)
    && filter_long_a == $past(cfg_wdata[4], 2) && path_a_source == $past(cfg_wdata[7:6], 2))
    else $error("loop A tuning wrong");
  a_c_set_low: assert property ((!set_select_pin)[*6] ##0 hit[8] ##1 !hit[8] |-> ##1
    pump_high_c == $past(cfg_wdata[3], 2) && filter_long_c == $past(cfg_wdata[4], 2))
    else $error("loop C low set wrong");
  a_c_set_high: assert property (set_select_pin[*6] ##0 hit[11] ##1 !hit[11] |-> ##1
    pump_high_c == $past(cfg_wdata[3], 2) && filter_long_c == $past(cfg_wdata[4], 2))
    else $error("loop C high set wrong");
  a_shut_idle: assert property ((!shutdown_input_pin)[*8] |->
    !loop_a_off && out_off == 4'h0) else $error("shutdown without pin");
  a_reset_zero: assert property ($rose(resetn) |-> ref_divide_a == 8'h00
    && path_a_source == 2'b00 && out_off == 4'h0) else $error("not clear after reset");
endmodule : cfg_checker

bind clkgen_config cfg_checker chk (.clk, .resetn, .cfg_wr, .cfg_addr, .cfg_wdata,
  .set_select_pin, .shutdown_input_pin, .ref_divide_a, .ref_divide_b, .a_count_a,
  .m_count_a, .filter_long_a, .pump_high_a, .filter_long_c, .pump_high_c, .loop_a_off,
  .path_a_source, .out_off);

// *** cfg_host.sv ***
// Host model that programs the configuration byte port
`timescale 1ns/1ps
module cfg_host (
  // Clock
  input wire logic clk,
  // Config port
  output logic cfg_wr,
  output logic [3:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_addr = 4'h0;
    cfg_wdata = 8'h00;
  end
  // Running outputs may glitch on divider or source writes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    cfg_addr = a;
    @(negedge clk);
    d = cfg_rdata;
  endtask : rd
endmodule : cfg_host

// *** pll_divider_config_decode_tb.sv ***
// Self-checking testbench of the configuration decoder
`timescale 1ns/1ps
module pll_divider_config_decode_tb;
  import clkgen_pkg::*;
  logic clk, resetn, set_select_pin, shutdown_input_pin, cfg_wr;
  logic [3:0] src_level, cfg_addr, out_off, out_clk;
  logic [7:0] cfg_wdata, cfg_rdata, rv;
  ref_div_t ref_divide_a, ref_divide_b, ref_divide_c;
  logic [2:0] a_count_a, a_count_b, a_count_c;
  logic [7:0] m_count_a, m_count_b, m_count_c;
  logic filter_long_a, filter_long_b, filter_long_c, pump_high_a, pump_high_b, pump_high_c;
  logic loop_a_off, loop_b_off, loop_c_off;
  logic [1:0] path_a_source, path_b_source, path_c_source, path_d_source;
  logic [127:0] sh;
  int bad_count, n_tests;
  int mods[16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 20, 25, 50};
  cfg_host host (.clk, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata);
  clkgen_config dut (.clk, .resetn, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .set_select_pin, .shutdown_input_pin, .src_level, .ref_divide_a, .a_count_a,
    .m_count_a, .filter_long_a, .pump_high_a, .loop_a_off, .ref_divide_b, .a_count_b,
    .m_count_b, .filter_long_b, .pump_high_b, .loop_b_off, .ref_divide_c, .a_count_c,
    .m_count_c, .filter_long_c, .pump_high_c, .loop_c_off, .path_a_source,
    .path_b_source, .path_c_source, .path_d_source, .out_off, .out_clk);
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // Source bit n rises every 2^(n+1) cycles
  always @(negedge clk) src_level <= src_level + 4'h1;
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    host.wr(a, d);
    sh[a*8 +: 8] = d;
  endtask : put
  task automatic read_all();
    for (int i = 0; i < 16; i++) begin
      host.rd(4'(i), rv);
      check(rv, sh[i*8 +: 8]);
    end
  endtask : read_all
  task automatic loops();
    logic s;
    s = set_select_pin;
    repeat (2) @(negedge clk);
    check(ref_divide_a, sh[7:0]);
    check(ref_divide_b, sh[31:24]);
    check(ref_divide_c, s ? sh[79:72] : sh[55:48]);
    check({m_count_a, a_count_a}, sh[18:8]);
    check({m_count_b, a_count_b}, sh[42:32]);
    check({m_count_c, a_count_c}, s ? sh[90:80] : sh[66:56]);
    check({filter_long_a, filter_long_b, pump_high_a, pump_high_b},
      {sh[20], sh[44], sh[19], sh[43]});
    check({filter_long_c, pump_high_c}, s ? sh[92:91] : sh[68:67]);
    check({path_a_source, path_b_source, path_c_source, path_d_source},
      {sh[23:22], sh[47:46], s ? sh[125:124] : sh[71:70], s ? sh[127:126] : sh[95:94]});
  endtask : loops
  task automatic measure();
    logic s;
    logic [3:0] prev, off;
    logic [1:0] sel[4];
    logic [3:0] code[4];
    int n[4];
    int e;
    s = set_select_pin;
    sel = '{sh[23:22], sh[47:46], s ? sh[125:124] : sh[71:70], s ? sh[127:126] : sh[95:94]};
    code = '{sh[99:96], sh[103:100], s ? sh[115:112] : sh[107:104],
      s ? sh[119:116] : sh[111:108]};
    off = shutdown_input_pin ? sh[123:120] : 4'h0;
    n = '{0, 0, 0, 0};
    repeat (8) @(negedge clk);
    prev = out_clk;
    repeat (800) begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) n[i] += int'(out_clk[i] & !prev[i]);
      prev = out_clk;
    end
    for (int i = 0; i < 4; i++) begin
      e = off[i] ? 0 : (400 >> sel[i]) / mods[code[i]];
      check(16'((n[i] - e) * (n[i] - e) <= 1 ? e : n[i]), 16'(e));
    end
  endtask : measure
  // ****
  // Sequence
  // ****
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'b0;
    set_select_pin = 1'b0;
    shutdown_input_pin = 1'b0;
    src_level = 4'h0;
    sh = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    read_all();
    measure();
    for (int i = 0; i < 12; i++) put(4'(i), {4'(i), ~4'(i)});
    put(4'hd, 8'h75);
    put(4'he, 8'h28);
    read_all();
    loops();
    for (int c = 0; c < 16; c++) begin
      put(4'hc, {~4'(c), 4'(c)});
      @(negedge clk);
      if (c > 1) check(out_clk[1:0], 2'b11);
      measure();
    end
    set_select_pin = 1'b1;
    repeat (8) @(negedge clk);
    loops();
    put(4'hb, 8'h5c);
    put(4'hf, 8'hd5);
    loops();
    measure();
    put(4'h2, 8'h2d);
    put(4'h5, 8'h25);
    put(4'h8, 8'h20);
    shutdown_input_pin = 1'b1;
    repeat (8) @(negedge clk);
    check({loop_a_off, loop_b_off, loop_c_off, out_off},
      {sh[21], sh[45], sh[69], sh[123:120]});
    measure();
    shutdown_input_pin = 1'b0;
    repeat (8) @(negedge clk);
    check({loop_a_off, loop_b_off, loop_c_off, out_off}, 16'h0000);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    sh = '0;
    read_all();
    tally_and_finish();
  end
endmodule : pll_divider_config_decode_tb
